// ---- logic/flash_status_link.sv ----
// Serial link front end: captures a frame and shifts status bytes out
`timescale 1ns/1ns
`include "flash_status_params.svh"

module flash_status_link (
  // Serial link
  input  wire logic                         sclk_i,
  input  wire logic                         cs_n_i,
  input  wire logic                         mosi_i,
  output logic                              miso_o,
  output logic                              miso_oe_n_o,
  // Core side
  input  wire logic [23:0]                  status_i,
  output flash_status_pkg::link_frame_t     frame_o
);
  import flash_status_pkg::*;

  logic [2:0]  bit_cnt_r;
  logic [2:0]  byte_idx_r;
  logic [6:0]  shift_r;
  logic        rd_act_r;
  logic [1:0]  rd_sel_r;
  logic [7:0]  tx_r;
  logic        miso_r;
  logic        oe_n_r;
  link_frame_t frame_r;
  logic [7:0]  byte_in;
  logic        byte_done;
  logic        op_rd;
  logic [1:0]  op_sel;

  function automatic logic [7:0] pick(input logic [23:0] s, input logic [1:0] sel);
    logic [7:0] b;
    b = s[7:0];
    if (sel == 2'h1) b = s[15:8];
    if (sel == 2'h2) b = s[23:16];
    return b;
  endfunction : pick

  assign byte_in   = {shift_r, mosi_i};
  assign byte_done = bit_cnt_r == 3'h7;
  assign op_rd     = byte_in == `OP_RDSR1 || byte_in == `OP_RDSR2 || byte_in == `OP_RDSR3;
  assign op_sel    = (byte_in == `OP_RDSR2) ? 2'h1 : (byte_in == `OP_RDSR3) ? 2'h2 : 2'h0;

  // ==========================================================
  // Frame counters, cleared by chip select since the link clock stops
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_r  <= 3'h0;
      byte_idx_r <= 3'h0;
      rd_act_r   <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done && byte_idx_r != `MAX_BYTES) begin
        byte_idx_r <= byte_idx_r + 3'h1;
      end
      if (byte_done && byte_idx_r == 3'h0) begin
        rd_act_r <= op_rd;
      end
    end
  end

  // Captured bytes outlive the frame so the core can read them after it ends
  always_ff @(posedge sclk_i) begin
    shift_r <= byte_in[6:0];
    if (bit_cnt_r == 3'h0 && byte_idx_r == 3'h0) begin
      frame_r.nbytes <= 3'h0;
    end
    if (byte_done) begin
      frame_r.nbytes <= (byte_idx_r == `MAX_BYTES) ? `MAX_BYTES : byte_idx_r + 3'h1;
      unique case (byte_idx_r)
        3'h0:    frame_r.op <= byte_in;
        3'h1:    frame_r.b1 <= byte_in;
        3'h2:    frame_r.b2 <= byte_in;
        3'h3:    frame_r.b3 <= byte_in;
        default: frame_r.b3 <= frame_r.b3;
      endcase
      if (byte_idx_r == 3'h0) begin
        rd_sel_r <= op_sel;
        tx_r     <= pick(status_i, op_sel);
      end else begin
        tx_r <= pick(status_i, rd_sel_r);
      end
    end
  end

  // ==========================================================
  // Read data leaves on the falling edge, half a cycle ahead of sampling
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      miso_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= ~rd_act_r;
      miso_r <= tx_r[3'(3'h7 - bit_cnt_r)];
    end
  end

  assign miso_o      = miso_r;
  assign miso_oe_n_o = oe_n_r;
  assign frame_o     = frame_r;

endmodule : flash_status_link

// ---- logic/flash_status_params.svh ----
// Opcodes, status bit positions, reset values and sizes of the flash status block
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

// ==========================================================
// Instruction codes
`define OP_WREN    8'h06
`define OP_WRDI    8'h04
`define OP_WRSR1   8'h01
`define OP_WRSR2   8'h31
`define OP_WRSR3   8'h11
`define OP_RDSR1   8'h05
`define OP_RDSR2   8'h35
`define OP_RDSR3   8'h15
`define OP_SUSPEND 8'h75
`define OP_RESUME  8'h7A
`define OP_PFX1    8'hAA
`define OP_PFX2    8'h55
`define OP_PROG    8'h02
`define OP_SE      8'h20
`define OP_BE      8'hD8
`define OP_CE      8'hC7
`define OP_LOCK    8'h36
`define OP_UNLOCK  8'h39

// ==========================================================
// Bit positions in the 24-bit status word (S0..S23)
`define S_WEL 1
`define S_BP  2
`define S_TB  5
`define S_SEC 6
`define S_SRP 7
`define S_SRL 8
`define S_QE  9
`define S_LB  11
`define S_CMP 14
`define S_SUS 15
`define S_WPS 18
`define S_DRV 21

// ==========================================================
// Reset values and sizes
`define DRV_RST      2'h3
`define BLK_LOCK_W   30
`define SEC_LOCK_W   32
`define ARRAY_SECS   10'h200
`define SECS_PER_BLK 10'h010
`define SECS_32K     10'h008
`define MAX_BYTES    3'h4

`endif

// ---- logic/flash_status_pkg.sv ----
// Types shared by the flash status block and its link front end
package flash_status_pkg;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [2:0] nbytes;
  } link_frame_t;

  typedef enum logic [1:0] {ARR_PAGE, ARR_SECTOR, ARR_BLOCK, ARR_CHIP} array_kind_t;

  typedef struct packed {
    array_kind_t kind;
    logic [20:0] addr;
  } array_cmd_t;

  typedef enum {OTP_IDLE, OTP_SEEN_AA, OTP_ARMED} otp_state_t;

endpackage : flash_status_pkg

// ---- logic/flash_status_protect_config.sv ----
// Status and configuration bits of a serial flash with write protection gating
`timescale 1ns/1ns
// Contract
// RULE_01: Top/bottom select 0 protects from top, 1 from bottom; resets to 0.
// RULE_02: Sector select 1 counts 4KB sectors, 0 counts 64KB blocks; resets to 0.
// RULE_03: Complement bit at S14, reset 0, inverts the protected region.
// RULE_04: Lock and protect both 0: pin ignored, write accepted when latch set.
// RULE_05: Protect bit 1, lock 0: writes rejected while protect pin low.
// RULE_06: Protect bit 1, lock 0: pin high and latch set accepts writes.
// RULE_07: Lock bit 1 refuses all status writes; power cycle clears it.
// RULE_08: Protect pin affects write permission only outside quad mode.
// RULE_09: Prefix AAh then 55h before locking makes the status permanently unwritable; perm_lock_r still clears on reset.
// RULE_10: Suspend flag S15 sets on 75h, clears on 7Ah or power cycle.
// RULE_11: Security locks S13..S11 reset 0, settable one by one, never cleared.
// RULE_12: Quad enable S9: 0 keeps pause pin, 1 turns pins into data lines.
// RULE_13: Scheme select 0 uses range bits, 1 uses individual lock bits.
// RULE_14: All individual lock bits are 1 after reset.
// RULE_15: Drive field 00/01/10/11 gives 100/75/50/25 percent; default 11.
// RULE_16: Reserved bits read as 0 and writes to them do nothing.
// RULE_17: Block protect field at S4..S2, reset 0, protects nothing.
// RULE_18: Program or erase overlapping a protected area is ignored.
// RULE_19: Write enable latch S1: set by 06h, cleared by 04h, writes, power-up.
// RULE_20: A rejected status write changes nothing and reports nothing.
// RULE_21: Suspend flag and latch ignore data of a status write.
`include "flash_status_params.svh"

module flash_status_protect_config (
  // System
  input  wire logic                         clk_i,
  input  wire logic                         resetn_i,
  // Serial link
  input  wire logic                         sclk_i,
  input  wire logic                         cs_n_i,
  input  wire logic                         mosi_i,
  output logic                              miso_o,
  output logic                              miso_oe_n_o,
  // Pins
  input  wire logic                         write_protect_n_i,
  // Array engine
  output logic                              array_go_o,
  output flash_status_pkg::array_cmd_t      array_cmd_o,
  // Configuration outputs
  output logic                              quad_enable_o,
  output logic                              pause_pin_enable_o,
  output logic [1:0]                        drive_strength_o,
  output logic [2:0]                        security_lock_o,
  output logic                              suspend_o
);
  import flash_status_pkg::*;

  // ==========================================================
  // Declarations
  logic                   cs_meta_r, cs_sync_r, cs_prev_r;
  logic                   wp_meta_r, wp_sync_r;
  link_frame_t            frame;
  logic [23:0]            snap_r;
  logic [23:0]            live;
  logic                   wel_r, tb_r, sec_r, srp_r, srl_r, qe_r, cmp_r, sus_r, wps_r;
  logic [2:0]             bp_r;
  logic [2:0]             lb_r;
  logic [1:0]             drv_r;
  logic                   perm_lock_r;
  logic                   pause_en_r;
  logic [`BLK_LOCK_W-1:0] blk_lock_r;
  logic [`SEC_LOCK_W-1:0] sec_lock_r;
  otp_state_t             otp_r, otp_nxt;
  logic                   array_go_r;
  array_cmd_t             array_cmd_r;
  logic                   frame_end, idle;
  logic [23:0]            wd;
  logic                   wp_ctrl, sr_ok, wr1_ok, wr2_ok, wr3_ok, wr_done;
  logic                   is_pp, is_se, is_be, is_ce, arr_cmd, arr_ok;
  logic                   is_lk, is_ul, lk_ok;
  logic [20:0]            addr;
  logic [4:0]             blk, bidx;
  logic                   edge_blk;
  logic [4:0]             sidx;
  logic [15:0]            sec_half;
  logic                   lock_hit, arr_hit;
  logic [9:0]             n_prot, lo_sec, hi_sec;
  logic                   wel_nxt;

  // ==========================================================
  // Helpers
  function automatic logic op_is(input link_frame_t f, input logic [7:0] code,
                                 input logic [2:0] need);
    return f.op == code && f.nbytes >= need;
  endfunction : op_is

  // Number of 4KB sectors covered by the block protect field
  function automatic logic [9:0] prot_count(input logic [2:0] bp, input logic sec);
    logic [9:0] n;
    n = 10'h000;
    if (bp[2:1] == 2'b11) n = `ARRAY_SECS;
    else if (bp == 3'h0) n = 10'h000;
    else if (!sec) n = 10'(`SECS_PER_BLK << (bp - 3'h1));
    else if (bp[2]) n = `SECS_32K;
    else n = 10'(10'h001 << (bp - 3'h1));
    return n;
  endfunction : prot_count

  // Overlap of sector range lo..hi with the protected region
  function automatic logic range_hit(input logic [9:0] n, input logic tb, input logic cmp,
                                     input logic [9:0] lo, input logic [9:0] hi);
    logic [9:0] start;
    logic       h;
    start = 10'(`ARRAY_SECS - n);
    unique case ({cmp, tb})
      2'b00: h = hi >= start;
      2'b01: h = lo < n;
      2'b10: h = lo < start;
      2'b11: h = hi >= n;
    endcase
    return h;
  endfunction : range_hit

  // ==========================================================
  // Crossings into the core clock
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
      wp_meta_r <= 1'b1;
      wp_sync_r <= 1'b1;
    end else begin
      cs_meta_r <= cs_n_i;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
      wp_meta_r <= write_protect_n_i;
      wp_sync_r <= wp_meta_r;
    end
  end

  // Frame bytes are stable once chip select is high: the link clock stops
  assign frame_end = cs_sync_r & ~cs_prev_r;
  assign idle      = cs_sync_r & cs_prev_r;

  flash_status_link u_link (
    .sclk_i      (sclk_i),
    .cs_n_i      (cs_n_i),
    .mosi_i      (mosi_i),
    .miso_o      (miso_o),
    .miso_oe_n_o (miso_oe_n_o),
    .status_i    (snap_r),
    .frame_o     (frame)
  );

  // ==========================================================
  // Status word as read back
  always_comb begin
    live                           = 24'h000000;
    live[`S_WEL]                   = wel_r;
    live[`S_BP+2:`S_BP]            = bp_r;
    live[`S_TB]                    = tb_r;
    live[`S_SEC]                   = sec_r;
    live[`S_SRP]                   = srp_r;
    live[`S_SRL]                   = srl_r;
    live[`S_QE]                    = qe_r;
    live[`S_LB+2:`S_LB]            = lb_r;
    live[`S_CMP]                   = cmp_r;
    live[`S_SUS]                   = sus_r;
    live[`S_WPS]                   = wps_r;
    live[`S_DRV+1:`S_DRV]          = drv_r;
  end

  // Snapshot only moves between frames, so the link reads a steady word
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      snap_r <= 24'h000000;
    end else if (idle) begin
      snap_r <= live; // RULE_16
    end
  end

  // ==========================================================
  // Status write permission
  assign wp_ctrl = srp_r & ~qe_r; // RULE_08
  assign sr_ok   = wel_r & ~srl_r & ~perm_lock_r & ~(wp_ctrl & ~wp_sync_r); // RULE_04 RULE_05 RULE_06 RULE_07
  assign wr1_ok  = frame_end & op_is(frame, `OP_WRSR1, 3'h2) & sr_ok;
  assign wr2_ok  = frame_end & sr_ok &
                   (op_is(frame, `OP_WRSR1, 3'h3) | op_is(frame, `OP_WRSR2, 3'h2));
  assign wr3_ok  = frame_end & op_is(frame, `OP_WRSR3, 3'h2) & sr_ok;
  assign wr_done = wr1_ok | wr2_ok | wr3_ok;
  assign wd      = {frame.b1, (frame.op == `OP_WRSR1) ? frame.b2 : frame.b1, frame.b1};

  // ==========================================================
  // Array command decode and protection check
  assign is_pp    = op_is(frame, `OP_PROG, 3'h4);
  assign is_se    = op_is(frame, `OP_SE, 3'h4);
  assign is_be    = op_is(frame, `OP_BE, 3'h4);
  assign is_ce    = op_is(frame, `OP_CE, 3'h1);
  assign is_lk    = op_is(frame, `OP_LOCK, 3'h4);
  assign is_ul    = op_is(frame, `OP_UNLOCK, 3'h4);
  assign arr_cmd  = frame_end & (is_pp | is_se | is_be | is_ce);
  assign lk_ok    = frame_end & (is_lk | is_ul) & wel_r;
  assign addr     = {frame.b1[4:0], frame.b2, frame.b3};
  assign blk      = addr[20:16];
  assign bidx     = 5'(blk - 5'h01);
  assign edge_blk = (blk == 5'h00) | (blk == 5'h1F);
  assign sidx     = {blk[0], addr[15:12]};
  assign sec_half = blk[0] ? sec_lock_r[31:16] : sec_lock_r[15:0];

  assign lock_hit = is_ce ? (|blk_lock_r | |sec_lock_r) :
                    is_be ? (edge_blk ? |sec_half : blk_lock_r[bidx]) :
                            (edge_blk ? sec_lock_r[sidx] : blk_lock_r[bidx]);

  assign n_prot = prot_count(bp_r, sec_r); // RULE_02 RULE_17
  assign lo_sec = is_ce ? 10'h000 : is_be ? {1'b0, blk, 4'h0} : {1'b0, addr[20:12]};
  assign hi_sec = is_ce ? 10'h1FF : is_be ? {1'b0, blk, 4'hF} : {1'b0, addr[20:12]};

  assign arr_hit = wps_r ? lock_hit : range_hit(n_prot, tb_r, cmp_r, lo_sec, hi_sec); // RULE_01 RULE_03 RULE_13
  assign arr_ok  = arr_cmd & wel_r & ~arr_hit; // RULE_18

  // ==========================================================
  // Write enable latch
  always_comb begin
    wel_nxt = wel_r;
    if (frame_end & op_is(frame, `OP_WREN, 3'h1)) begin
      wel_nxt = 1'b1;
    end else if ((frame_end & op_is(frame, `OP_WRDI, 3'h1)) | wr_done | arr_cmd | lk_ok) begin
      wel_nxt = 1'b0; // RULE_19
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wel_r <= 1'b0;
    end else begin
      wel_r <= wel_nxt;
    end
  end

  // ==========================================================
  // Protection and configuration bits; a rejected write leaves them all alone
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      bp_r  <= 3'h0;
      tb_r  <= 1'b0;
      sec_r <= 1'b0;
      srp_r <= 1'b0;
    end else if (wr1_ok) begin // RULE_20
      bp_r  <= wd[`S_BP+2:`S_BP]; // RULE_17
      tb_r  <= wd[`S_TB]; // RULE_01
      sec_r <= wd[`S_SEC]; // RULE_02
      srp_r <= wd[`S_SRP];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      srl_r <= 1'b0; // RULE_07
      qe_r  <= 1'b0;
      lb_r  <= 3'h0;
      cmp_r <= 1'b0;
    end else if (wr2_ok) begin
      srl_r <= wd[`S_SRL];
      qe_r  <= wd[`S_QE]; // RULE_12
      lb_r  <= lb_r | wd[`S_LB+2:`S_LB]; // RULE_11
      cmp_r <= wd[`S_CMP]; // RULE_03
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wps_r <= 1'b0;
      drv_r <= `DRV_RST; // RULE_15
    end else if (wr3_ok) begin
      wps_r <= wd[`S_WPS]; // RULE_13
      drv_r <= wd[`S_DRV+1:`S_DRV]; // RULE_15
    end
  end

  // Suspend flag is never taken from write data
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sus_r <= 1'b0;
    end else if (frame_end & op_is(frame, `OP_SUSPEND, 3'h1)) begin
      sus_r <= 1'b1; // RULE_10 RULE_21
    end else if (frame_end & op_is(frame, `OP_RESUME, 3'h1)) begin
      sus_r <= 1'b0; // RULE_10
    end
  end

  // ==========================================================
  // One-time lock prefix sequence
  always_comb begin
    otp_nxt = otp_r;
    if (frame_end) begin
      unique case (otp_r)
        OTP_IDLE:    otp_nxt = op_is(frame, `OP_PFX1, 3'h1) ? OTP_SEEN_AA : OTP_IDLE;
        OTP_SEEN_AA: otp_nxt = op_is(frame, `OP_PFX2, 3'h1) ? OTP_ARMED : OTP_IDLE;
        OTP_ARMED:   otp_nxt = OTP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      otp_r       <= OTP_IDLE;
      perm_lock_r <= 1'b0;
    end else begin
      otp_r <= otp_nxt;
      if (wr2_ok && otp_r == OTP_ARMED && wd[`S_SRL]) begin
        perm_lock_r <= 1'b1; // RULE_09
      end
    end
  end

  // ==========================================================
  // Individual locks: edge blocks lock per sector, the rest per block
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      blk_lock_r <= '1; // RULE_14
      sec_lock_r <= '1; // RULE_14
    end else if (lk_ok && edge_blk) begin
      sec_lock_r[sidx] <= is_lk;
    end else if (lk_ok) begin
      blk_lock_r[bidx] <= is_lk;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      array_go_r  <= 1'b0;
      array_cmd_r <= '0;
      pause_en_r  <= 1'b1;
    end else begin
      array_go_r <= arr_ok; // RULE_18
      pause_en_r <= ~qe_r; // RULE_12
      if (arr_ok) begin
        array_cmd_r.addr <= addr;
        array_cmd_r.kind <= is_ce ? ARR_CHIP : is_be ? ARR_BLOCK :
                            is_se ? ARR_SECTOR : ARR_PAGE;
      end
    end
  end

  assign array_go_o         = array_go_r;
  assign array_cmd_o        = array_cmd_r;
  assign quad_enable_o      = qe_r;
  assign pause_pin_enable_o = pause_en_r;
  assign drive_strength_o   = drv_r;
  assign security_lock_o    = lb_r;
  assign suspend_o          = sus_r;

endmodule : flash_status_protect_config

// ---- verif/flash_status_chk_sva.sv ----
// Port-level assertions for the flash status block
`timescale 1ns/1ns
module flash_status_chk (
  // System
  input wire logic                         clk_i,
  input wire logic                         resetn_i,
  // Link and array engine
  input wire logic                         cs_n_i,
  input wire logic                         array_go_o,
  input wire flash_status_pkg::array_cmd_t array_cmd_o,
  // Configuration
  input wire logic                         quad_enable_o,
  input wire logic                         pause_pin_enable_o,
  input wire logic [1:0]                   drive_strength_o,
  input wire logic [2:0]                   security_lock_o,
  input wire logic                         suspend_o
);
  import flash_status_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // Assertions
  chk_pause_tracks_quad: assert property (
    $rose(quad_enable_o) |-> pause_pin_enable_o ##1 !pause_pin_enable_o)
    else $error("pause enable did not drop one cycle after quad enable");
  chk_go_one_cycle: assert property (
    array_go_o |=> !array_go_o)
    else $error("array go longer than one cycle");
  chk_go_after_frame: assert property (
    array_go_o |-> cs_n_i && $past(cs_n_i, 3))
    else $error("array go without a closed frame");
  chk_cmd_holds: assert property (
    !array_go_o |-> $stable(array_cmd_o))
    else $error("array command moved without go");
  chk_security_sticky: assert property (
    ($past(security_lock_o) & ~security_lock_o) == 3'h0)
    else $error("security lock bit cleared");
  chk_quiet_in_frame: assert property (
    (!cs_n_i)[*6] |-> $stable({quad_enable_o, drive_strength_o, security_lock_o, suspend_o}))
    else $error("configuration changed inside a frame");
  chk_reset_defaults: assert property (
    $rose(resetn_i) |-> drive_strength_o == 2'h3 && security_lock_o == 3'h0
                        && !suspend_o && pause_pin_enable_o)
    else $error("wrong configuration after reset");
  chk_suspend_at_end: assert property (
    $changed(suspend_o) |-> cs_n_i && $past(cs_n_i, 3))
    else $error("suspend flag changed outside frame end");
endmodule : flash_status_chk

bind flash_status_protect_config flash_status_chk i_chk (
  .clk_i, .resetn_i, .cs_n_i, .array_go_o, .array_cmd_o, .quad_enable_o,
  .pause_pin_enable_o, .drive_strength_o, .security_lock_o, .suspend_o);

// ---- verif/spi_host_model.sv ----
// Serial link host that frames instructions in clock mode 0
`timescale 1ns/1ns
module spi_host_model (
  // System
  input  wire logic clk_i,
  // Serial link
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // ==========================================================
  // One frame: nbytes from the top of data, MSB first; rd holds the last 8 bits seen
  task automatic frame(input logic [31:0] data, input int nbytes, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    @(posedge clk_i);
    #7 cs_n_o = 1'b0;
    for (i = 0; i < nbytes * 8; i++) begin
      mosi_o = data[31 - i];
      #62 sclk_o = 1'b1;
      rd = {rd[6:0], miso_i};
      #63 sclk_o = 1'b0;
    end
    #30 cs_n_o = 1'b1;
    // Released line must not keep a stale bit
    mosi_o = ~mosi_o;
    // Gap lets the core settle and refresh its read snapshot
    #600;
  endtask : frame
endmodule : spi_host_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the flash status block
`timescale 1ns/1ns
`include "flash_status_params.svh"
module tb_top;
  import flash_status_pkg::*;
  logic       clk_i    = 1'b0;
  logic       resetn_i = 1'b0;
  logic       wp_n     = 1'b1;
  wire        sclk, cs_n, mosi, miso, miso_oe_n, miso_w;
  logic       go, qe, pause, susp;
  logic [1:0] drv;
  logic [2:0] slk;
  array_cmd_t cmd, last_cmd;
  int         mismatches = 0, compares = 0, cycles = 0, go_cnt = 0;
  logic [7:0] v;

  always #25 clk_i = ~clk_i;
  // Device output floats while its enable is off
  assign miso_w = miso_oe_n ? 1'bz : miso;

  flash_status_protect_config i_dut (
    .clk_i, .resetn_i, .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_n_o(miso_oe_n), .write_protect_n_i(wp_n), .array_go_o(go),
    .array_cmd_o(cmd), .quad_enable_o(qe), .pause_pin_enable_o(pause),
    .drive_strength_o(drv), .security_lock_o(slk), .suspend_o(susp));
  spi_host_model i_host (.clk_i, .miso_i(miso_w), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

  // ==========================================================
  // Monitor and hang guard
  // Falling edge keeps the go pulse and its command clear of the launching edge
  always @(negedge clk_i) begin
    cycles++;
    if (go === 1'b1) begin
      go_cnt++;
      last_cmd = cmd;
    end
    if (cycles == 40000) begin
      mismatches++;
      conclude();
    end
  end

  // ==========================================================
  // Helpers
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic op(input logic [7:0] c);
    i_host.frame({c, 24'h0}, 1, v);
  endtask : op

  task automatic raw(input logic [7:0] c, input logic [7:0] d);
    i_host.frame({c, d, 16'h0}, 2, v);
  endtask : raw

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    op(`OP_WREN);
    raw(c, d);
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [7:0] exp, input string name);
    i_host.frame({c, 24'h0}, 2, v);
    chk(name, {24'h0, exp}, {24'h0, v});
  endtask : rd

  task automatic erase(input logic [23:0] a, input logic exp_go);
    int n;
    n = go_cnt;
    op(`OP_WREN);
    i_host.frame({`OP_SE, a}, 4, v);
    chk("erase go", {31'h0, exp_go}, go_cnt - n);
    if (exp_go)
      chk("erase cmd", {9'h0, ARR_SECTOR, a[20:0]}, {9'h0, last_cmd});
  endtask : erase

  task automatic pin(input logic l);
    @(posedge clk_i);
    wp_n <= l;
    repeat (3) @(posedge clk_i);
  endtask : pin

  task automatic do_reset();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : do_reset

  // ==========================================================
  // Scenarios
  task automatic t_defaults();
    rd(`OP_RDSR1, 8'h00, "sr1 reset");
    rd(`OP_RDSR2, 8'h00, "sr2 reset");
    rd(`OP_RDSR3, 8'h60, "sr3 reset");
    chk("pause", 32'h1, pause);
  endtask : t_defaults

  task automatic t_wel();
    raw(`OP_WRSR1, 8'h7C);
    rd(`OP_RDSR1, 8'h00, "no latch");
    op(`OP_WREN);
    rd(`OP_RDSR1, 8'h02, "latch set");
    raw(`OP_WRSR1, 8'h7F);
    rd(`OP_RDSR1, 8'h7C, "sr1 data");
    op(`OP_WREN);
    op(`OP_WRDI);
    raw(`OP_WRSR1, 8'h00);
    rd(`OP_RDSR1, 8'h7C, "after wrdi");
    wr(`OP_WRSR1, 8'h00);
  endtask : t_wel

  task automatic t_protect();
    logic [7:0]  s1 [8] = '{8'h04, 8'h04, 8'h24, 8'h24, 8'h44, 8'h44, 8'h04, 8'h04};
    logic        cp [8] = '{0, 0, 0, 0, 0, 0, 1, 1};
    logic [23:0] ad [8] = '{24'h1F0000, 24'h1E0000, 24'h000000, 24'h010000,
                            24'h1FF000, 24'h1FE000, 24'h1F0000, 24'h1E0000};
    logic        gg [8] = '{0, 1, 0, 1, 0, 1, 1, 0};
    for (int i = 0; i < 8; i++) begin
      wr(`OP_WRSR1, s1[i]);
      wr(`OP_WRSR2, {1'b0, cp[i], 6'h0});
      erase(ad[i], gg[i]);
      rd(`OP_RDSR1, s1[i], "latch after erase");
    end
    wr(`OP_WRSR2, 8'h00);
    wr(`OP_WRSR1, 8'h00);
  endtask : t_protect

  task automatic t_wp();
    wr(`OP_WRSR1, 8'h80);
    pin(1'b0);
    wr(`OP_WRSR1, 8'h84);
    rd(`OP_RDSR1, 8'h82, "pin low");
    pin(1'b1);
    raw(`OP_WRSR1, 8'h84);
    rd(`OP_RDSR1, 8'h84, "pin high");
    wr(`OP_WRSR2, 8'h02);
    chk("quad", 32'h1, qe);
    chk("pause", 32'h0, pause);
    pin(1'b0);
    wr(`OP_WRSR1, 8'h80);
    rd(`OP_RDSR1, 8'h80, "quad pin low");
    pin(1'b1);
    wr(`OP_WRSR2, 8'h00);
    wr(`OP_WRSR1, 8'h00);
  endtask : t_wp

  task automatic t_lock();
    op(`OP_WREN);
    op(`OP_PFX1);
    op(`OP_PFX2);
    raw(`OP_WRSR2, 8'h01);
    rd(`OP_RDSR2, 8'h01, "lock set");
    wr(`OP_WRSR1, 8'h04);
    rd(`OP_RDSR1, 8'h02, "locked");
    do_reset();
    rd(`OP_RDSR2, 8'h00, "lock power cycle");
  endtask : t_lock

  task automatic t_suspend();
    op(`OP_SUSPEND);
    rd(`OP_RDSR2, 8'h80, "suspend");
    wr(`OP_WRSR2, 8'h00);
    chk("suspend kept", 32'h1, susp);
    op(`OP_RESUME);
    chk("resume", 32'h0, susp);
    wr(`OP_WRSR2, 8'h80);
    rd(`OP_RDSR2, 8'h00, "suspend data");
  endtask : t_suspend

  task automatic t_security();
    wr(`OP_WRSR2, 8'h08);
    chk("sec one", 32'h1, slk);
    wr(`OP_WRSR2, 8'h30);
    wr(`OP_WRSR2, 8'h00);
    rd(`OP_RDSR2, 8'h38, "sec sticky");
  endtask : t_security

  task automatic t_drive();
    for (int d = 0; d < 4; d++) begin
      wr(`OP_WRSR3, {1'b0, d[1:0], 5'h0});
      chk("drive", d, drv);
    end
    // Reserved positions written with ones on purpose
    wr(`OP_WRSR3, 8'hFF);
    rd(`OP_RDSR3, 8'h64, "reserved");
  endtask : t_drive

  task automatic t_scheme();
    int n;
    erase(24'h000000, 1'b0);
    op(`OP_WREN);
    i_host.frame({`OP_UNLOCK, 24'h000000}, 4, v);
    erase(24'h000000, 1'b1);
    erase(24'h010000, 1'b0);
    n = go_cnt;
    op(`OP_WREN);
    op(`OP_CE);
    chk("chip erase go", 32'h0, go_cnt - n);
  endtask : t_scheme

  initial begin
    do_reset();
    t_defaults();
    t_wel();
    t_protect();
    t_wp();
    t_lock();
    t_suspend();
    t_security();
    t_drive();
    t_scheme();
    conclude();
  end
endmodule : tb_top
